// ---- scoc_card.sv ----
/*
 * serial control option card: bus buffer gating, address latch and
 * decode, serial-port interrupt gating, card clock divider, baud timer
 * and the pod shift register with its burst counter.
 * assumes the uart and pod are outside; all their pins are asynchronous.
 */
// Behaviour
// (R1) data buffer joined only while slot selected
// (R2) latch low address byte on strobe
// (R3) decoder enabled by slot select and A15
// (R4) decode rom/ram on memory, uart/id on io
// (R5) processor reads id then picks slot line
// (R6) serial port uses txd, rxd, dsr only
// (R7) processor programs uart before transfers
// (R8) interrupt on tx empty or rx full
// (R9) interrupt passed only while card enabled
// (R10) tx empty interrupt gated by transmit mode
// (R11) card clock divided from processor clock
// (R12) baud timer gives sixteen times baud rate
// (R13) pod control and choose lines from port
// (R14) pod clock, outbound and inbound through buffer
// (R15) load high loads byte, low shifts out
// (R16) load low shifts pod data in
// (R17) pod clock uses the card clock divider
// (R18) cleared counter passes eight clocks, halts
// (R19) preset 1110 passes one clock, halts
// (R20) shift register runs msb first
// (R21) processor reset silences irq, buffer, counter
`timescale 1ns/1ps
`default_nettype none
module scoc_card import scoc_pkg::*; (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// processor bus pins
	input  wire logic        slot_select,
	input  wire logic        addr_a15,
	input  wire logic        addr_a14,
	input  wire logic        io_m,
	input  wire logic        ale,
	input  wire logic        proc_reset_out,
	input  wire logic [7:0]  ad_in,
	output logic             data_buf_en_n,
	output logic [7:0]       latched_addr,
	output logic             prog_rom_sel_n,
	output logic             scratch_ram_sel_n,
	output logic             serial_port_sel_n,
	output logic             id_buffer_sel_n,
	output logic             card_irq_out_n,
	// uart chip side
	input  wire logic        tx_buffer_empty,
	input  wire logic        rx_buffer_full,
	input  wire logic        uart_txd,
	output logic             uart_rxd,
	output logic             dsr_seen,
	output logic             divided_card_clock,
	output logic             baud_tick,
	// serial port pins
	output logic             txd,
	input  wire logic        rxd,
	input  wire logic        dsr,
	// emulator pod link
	output logic             pod_ctrl_0,
	output logic             pod_ctrl_1,
	output logic             pod_choose_0,
	output logic             pod_choose_1,
	output logic             pod_shift_clock,
	output logic             pod_outbound_line,
	input  wire logic        pod_inbound_line
);
	logic [PIN_W-1:0] pin_s1_ff, pin_s2_ff;
	logic        slot_s, a15_s, a14_s, io_s, ale_s, prst_s, txe_s, rxf_s;
	logic        txd_s, rxd_s, dsr_s, inb_s;
	logic [7:0]  ad_s;
	logic        ale_d_ff;
	logic        pready_ff, pslverr_ff;
	logic [31:0] prdata_ff;
	logic [7:0]  ctrl_ff, pod_data_ff, sr_ff, lat_ff;
	logic [15:0] baud_reload_ff, baud_cnt_ff;
	logic [3:0]  cnt_ff, div_ff;
	logic        card_en, card_clk_ff, running, pod_pulse;
	logic        wr_acc, rd_acc, addr_ok, cmd_clear, cmd_preset, baud_wr;
	logic        dec_en, irq_req;
	logic        buf_n_ff, rom_n_ff, ram_n_ff, uart_n_ff, id_n_ff, irq_n_ff;
	logic        txd_ff, rxd_ff, dsr_ff, tick_ff, pclk_ff, out_ff;
	logic [31:0] nxt_prdata;
	// two-stage capture of every asynchronous pin
	always_ff @(posedge clk) begin
		if (rst) begin
			pin_s1_ff <= '0;
			pin_s2_ff <= '0;
		end else begin
			pin_s1_ff <= {slot_select, addr_a15, addr_a14, io_m, ale, proc_reset_out,
				tx_buffer_empty, rx_buffer_full, uart_txd, rxd, dsr, pod_inbound_line, ad_in};
			pin_s2_ff <= pin_s1_ff;
		end
	end
	assign {slot_s, a15_s, a14_s, io_s, ale_s, prst_s, txe_s, rxf_s,
		txd_s, rxd_s, dsr_s, inb_s, ad_s} = pin_s2_ff;
	// apb decode; writes land on the edge that sees pready high
	assign wr_acc     = psel & penable & pready_ff & pwrite;
	assign rd_acc     = psel & penable & ~pready_ff & ~pwrite;
	assign addr_ok    = paddr inside {OFS_CTRL, OFS_POD, OFS_COUNT, OFS_BAUD, OFS_STATUS};
	assign cmd_clear  = wr_acc & (paddr == OFS_COUNT) & pwdata[CMD_CLEAR];
	assign cmd_preset = wr_acc & (paddr == OFS_COUNT) & pwdata[CMD_PRESET];
	assign baud_wr    = wr_acc & (paddr == OFS_BAUD);
	// read mux, registered so the bus sees flop outputs
	always_comb begin
		nxt_prdata = '0;
		unique case (paddr)
			OFS_CTRL:   nxt_prdata[7:0] = ctrl_ff;
			OFS_POD:    nxt_prdata[7:0] = sr_ff; // (R16)
			OFS_COUNT:  nxt_prdata[4:0] = {~running, cnt_ff};
			OFS_BAUD:   nxt_prdata[15:0] = baud_reload_ff;
			OFS_STATUS: nxt_prdata[3:0] = {~running, dsr_s, rxf_s, txe_s};
			default:    nxt_prdata = '0;
		endcase
	end
	// one wait state, then answer; unmapped offsets get pslverr
	always_ff @(posedge clk) begin
		if (rst) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= '0;
		end else begin
			pready_ff  <= psel & penable & ~pready_ff;
			pslverr_ff <= psel & penable & ~pready_ff & ~addr_ok;
			prdata_ff  <= rd_acc ? nxt_prdata : '0;
		end
	end
	// software registers: control port and pod byte
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_ff     <= CTRL_RST;
			pod_data_ff <= '0;
		end else if (wr_acc && paddr == OFS_CTRL) begin
			ctrl_ff <= pwdata[7:0]; // (R13)
		end else if (wr_acc && paddr == OFS_POD) begin
			pod_data_ff <= pwdata[7:0];
		end
	end
	// card clock divider; also times the pod shift clock
	always_ff @(posedge clk) begin
		if (rst) begin
			div_ff      <= '0;
			card_clk_ff <= 1'b0;
		end else if (div_ff == CARD_DIV_LAST) begin
			div_ff      <= '0; // (R11)
			card_clk_ff <= ~card_clk_ff;
		end else begin
			div_ff <= div_ff + 4'd1;
		end
	end
	assign card_en   = (div_ff == CARD_DIV_LAST) & ~card_clk_ff;
	assign running   = (cnt_ff != CNT_TC_8) && (cnt_ff != CNT_TC_1);
	assign pod_pulse = card_en & running; // (R17)
	// burst counter: halts on either terminal count until told again
	always_ff @(posedge clk) begin
		if (rst || prst_s) begin
			cnt_ff <= CNT_TC_1; // (R21)
		end else if (cmd_clear) begin
			cnt_ff <= '0; // (R18)
		end else if (cmd_preset) begin
			cnt_ff <= CNT_PRESET; // (R19)
		end else if (pod_pulse) begin
			cnt_ff <= cnt_ff + 4'd1;
		end
	end
	// shift register: parallel load or msb-first shift on each pod clock
	always_ff @(posedge clk) begin
		if (rst) begin
			sr_ff <= '0;
		end else if (pod_pulse && ctrl_ff[CTRL_LOAD]) begin
			sr_ff <= pod_data_ff; // (R15)
		end else if (pod_pulse) begin
			sr_ff <= {sr_ff[6:0], inb_s}; // (R16) (R20)
		end
	end
	// pod line buffer; clock pulses only while the burst runs
	always_ff @(posedge clk) begin
		if (rst) begin
			pclk_ff <= 1'b0;
			out_ff  <= 1'b0;
		end else begin
			pclk_ff <= pod_pulse; // (R14)
			out_ff  <= sr_ff[7]; // (R20)
		end
	end
	// baud timer, reloaded by software when a transfer starts
	always_ff @(posedge clk) begin
		if (rst) begin
			baud_reload_ff <= BAUD_RST;
			baud_cnt_ff    <= BAUD_RST;
			tick_ff        <= 1'b0;
		end else if (baud_wr) begin
			baud_reload_ff <= pwdata[15:0]; // (R12)
			baud_cnt_ff    <= pwdata[15:0];
			tick_ff        <= 1'b0;
		end else if (baud_cnt_ff == '0) begin
			baud_cnt_ff <= baud_reload_ff;
			tick_ff     <= (baud_reload_ff != '0); // zero reload keeps it quiet
		end else begin
			baud_cnt_ff <= baud_cnt_ff - 16'd1;
			tick_ff     <= 1'b0;
		end
	end
	// three-wire serial port passed between pins and uart
	always_ff @(posedge clk) begin
		if (rst) begin
			txd_ff <= 1'b1;
			rxd_ff <= 1'b1;
			dsr_ff <= 1'b0;
		end else begin
			txd_ff <= txd_s; // (R6)
			rxd_ff <= rxd_s;
			dsr_ff <= dsr_s;
		end
	end
	// slot gating and address latch; the latch keeps taking strobes through a reset pulse
	assign dec_en = slot_s & a15_s; // (R3)
	always_ff @(posedge clk) begin
		if (rst) begin
			buf_n_ff <= 1'b1;
			ale_d_ff <= 1'b0;
			lat_ff   <= '0;
		end else begin
			buf_n_ff <= ~slot_s | prst_s; // (R1) (R21)
			ale_d_ff <= ale_s;
			if (ale_s && !ale_d_ff) begin
				lat_ff <= ad_s; // (R2)
			end
		end
	end
	// window decode; io_m high marks an io cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			{rom_n_ff, ram_n_ff, uart_n_ff, id_n_ff} <= 4'hF;
		end else begin
			rom_n_ff  <= ~(dec_en & ~io_s & ~a14_s); // (R4)
			ram_n_ff  <= ~(dec_en & ~io_s & a14_s);
			uart_n_ff <= ~(dec_en & io_s & ~a14_s);
			id_n_ff   <= ~(dec_en & io_s & a14_s); // (R5)
		end
	end
	// interrupt: tx empty only in transmit mode, all gated by enable
	assign irq_req = (txe_s & ctrl_ff[CTRL_TX_GATE]) | rxf_s; // (R8) (R10)
	always_ff @(posedge clk) begin
		if (rst || prst_s) begin
			irq_n_ff <= 1'b1; // (R21)
		end else begin
			irq_n_ff <= ~(ctrl_ff[CTRL_IRQ_EN] & irq_req); // (R9)
		end
	end
	// outputs
	assign pready             = pready_ff;
	assign prdata             = prdata_ff;
	assign pslverr            = pslverr_ff;
	assign data_buf_en_n      = buf_n_ff;
	assign latched_addr       = lat_ff;
	assign prog_rom_sel_n     = rom_n_ff;
	assign scratch_ram_sel_n  = ram_n_ff;
	assign serial_port_sel_n  = uart_n_ff;
	assign id_buffer_sel_n    = id_n_ff;
	assign card_irq_out_n     = irq_n_ff;
	assign uart_rxd           = rxd_ff;
	assign dsr_seen           = dsr_ff;
	assign divided_card_clock = card_clk_ff;
	assign baud_tick          = tick_ff;
	assign txd                = txd_ff;
	assign {pod_choose_1, pod_choose_0, pod_ctrl_1, pod_ctrl_0} = ctrl_ff[7:CTRL_POD_LO];
	assign pod_shift_clock    = pclk_ff;
	assign pod_outbound_line  = out_ff;
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_clear_cmd;
		cmd_clear && !prst_s;
	endsequence
	sequence s_burst_open;
		cnt_ff == 4'h0 && running;
	endsequence
	property p_buf_off;
		!slot_s && !prst_s |=> data_buf_en_n;
	endproperty
	a_buf_off: assert property (p_buf_off) else $error("buffer on while unselected"); // (R1)
	property p_latch;
		ale_s && !ale_d_ff && !prst_s |=> latched_addr == $past(ad_s);
	endproperty
	a_latch: assert property (p_latch) else $error("address not latched"); // (R2)
	property p_dec_off;
		!dec_en |=> prog_rom_sel_n && scratch_ram_sel_n && serial_port_sel_n && id_buffer_sel_n;
	endproperty
	a_dec_off: assert property (p_dec_off) else $error("decode outside window"); // (R3)
	property p_irq_off;
		!ctrl_ff[CTRL_IRQ_EN] |=> card_irq_out_n;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("irq while disabled"); // (R9)
	property p_rx_irq;
		ctrl_ff[CTRL_IRQ_EN] && rxf_s && !prst_s |=> !card_irq_out_n;
	endproperty
	a_rx_irq: assert property (p_rx_irq) else $error("rx full irq missing"); // (R8)
	property p_tx_gate;
		!ctrl_ff[CTRL_TX_GATE] && !rxf_s |=> card_irq_out_n;
	endproperty
	a_tx_gate: assert property (p_tx_gate) else $error("tx irq outside tx mode"); // (R10)
	property p_burst;
		s_clear_cmd |=> s_burst_open;
	endproperty
	a_burst: assert property (p_burst) else $error("burst did not open"); // (R18)
	property p_halt;
		!running && !cmd_clear && !cmd_preset && !prst_s |=> $stable(cnt_ff) && !pod_shift_clock;
	endproperty
	a_halt: assert property (p_halt) else $error("counter moved while halted"); // (R18)
	property p_preset;
		cmd_preset && !cmd_clear && !prst_s |=> cnt_ff == CNT_PRESET;
	endproperty
	a_preset: assert property (p_preset) else $error("preset value wrong"); // (R19)
	property p_load;
		pod_pulse && ctrl_ff[CTRL_LOAD] |=> sr_ff == $past(pod_data_ff) ##1 pod_shift_clock == 1'b0;
	endproperty
	a_load: assert property (p_load) else $error("parallel load failed"); // (R15)
	property p_shift;
		pod_pulse && !ctrl_ff[CTRL_LOAD] |=> sr_ff == {$past(sr_ff[6:0]), $past(inb_s)};
	endproperty
	a_shift: assert property (p_shift) else $error("shift in failed"); // (R16)
	property p_rst_out;
		prst_s |=> card_irq_out_n && data_buf_en_n && cnt_ff == CNT_TC_1;
	endproperty
	a_rst_out: assert property (p_rst_out) else $error("reset out not honoured"); // (R21)
endmodule : scoc_card
`default_nettype wire

// ---- scoc_card_tb.sv ----
/*
 * self-checking bench for the option card: apb map, pin decode,
 * interrupt gating, serial copies, baud timer, card clock, pod bursts.
 * assumes scoc_pkg, scoc_card and scoc_pod_model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module scoc_card_tb import scoc_pkg::*; ;
	logic        clk, rst, psel, penable, pwrite, pready, pslverr, err, p;
	logic        slot_select, addr_a15, addr_a14, io_m, ale, proc_reset_out;
	logic        data_buf_en_n, prog_rom_sel_n, scratch_ram_sel_n, serial_port_sel_n;
	logic        id_buffer_sel_n, card_irq_out_n, tx_buffer_empty, rx_buffer_full;
	logic        uart_txd, uart_rxd, dsr_seen, divided_card_clock, baud_tick, txd, rxd, dsr;
	logic        pod_ctrl_0, pod_ctrl_1, pod_choose_0, pod_choose_1, pod_shift_clock;
	logic        pod_outbound_line, pod_inbound_line, in_level, pclr;
	logic [7:0]  paddr, ad_in, latched_addr, rx_byte;
	logic [3:0]  rx_count;
	logic [31:0] pwdata, prdata, rd, v;
	int          mismatches, total_checks, n;

	scoc_card i_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
		.pslverr, .slot_select, .addr_a15, .addr_a14, .io_m, .ale, .proc_reset_out, .ad_in,
		.data_buf_en_n, .latched_addr, .prog_rom_sel_n, .scratch_ram_sel_n, .serial_port_sel_n,
		.id_buffer_sel_n, .card_irq_out_n, .tx_buffer_empty, .rx_buffer_full, .uart_txd,
		.uart_rxd, .dsr_seen, .divided_card_clock, .baud_tick, .txd, .rxd, .dsr, .pod_ctrl_0,
		.pod_ctrl_1, .pod_choose_0, .pod_choose_1, .pod_shift_clock, .pod_outbound_line,
		.pod_inbound_line);
	scoc_pod_model i_pod (.clk, .clr(pclr), .in_level, .pod_shift_clock, .pod_outbound_line,
		.pod_inbound_line, .rx_byte, .rx_count);

	// 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// {buffer off, rom, ram, uart, id}; s = {io, a14, a15, slot}
	function automatic logic [4:0] exp_dec(input logic [3:0] s, input logic pr);
		logic [3:0] sel;
		sel = 4'hF;
		if (s[0] && s[1]) sel[~s[3:2]] = 1'b0;
		return {!s[0] || pr, sel};
	endfunction : exp_dec

	// c = {tx gate, irq enable}, s = {rx full, tx empty}
	function automatic logic exp_irq_n(input logic [1:0] c, input logic [1:0] s, input logic pr);
		return pr || !(c[0] && ((s[0] && c[1]) || s[1]));
	endfunction : exp_irq_n

	task automatic check(input string what, input logic [39:0] exp, input logic [39:0] got);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	// one apb transfer; entered just after a rising edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1 && k < 20) begin
			@(posedge clk);
			k++;
		end
		rd = prdata;
		err = pslverr;
		if (k >= 20) mismatches++;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb

	// measures the gap between two baud ticks
	task automatic baud_run(input logic [15:0] r);
		apb(1'b1, OFS_BAUD, {16'h0000, r});
		n = 0;
		while (baud_tick !== 1'b1 && n < 100) begin
			@(posedge clk);
			n++;
		end
		@(posedge clk);
		n = 1;
		while (baud_tick !== 1'b1 && n < 100) begin
			@(posedge clk);
			n++;
		end
		check("baud period", r + 1, n);
	endtask : baud_run

	// count command, then pulses seen by the pod and the counter state
	task automatic pod_cmd(input logic [1:0] cmd, input int pulses, input logic [7:0] cnt);
		pclr <= 1'b1;
		@(posedge clk);
		pclr <= 1'b0;
		apb(1'b1, OFS_COUNT, {30'h0, cmd});
		repeat (40) @(posedge clk);
		check("pulses", pulses, rx_count);
		apb(1'b0, OFS_COUNT, '0);
		check("count", cnt, rd);
	endtask : pod_cmd

	task automatic complete_run;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : complete_run

	// hang guard, well beyond the expected run
	initial begin
		#400_000;
		mismatches++;
		complete_run();
	end

	initial begin
		{psel, penable, pwrite, paddr, pwdata, slot_select, addr_a15, addr_a14} = '0;
		{io_m, ale, proc_reset_out, ad_in, tx_buffer_empty, rx_buffer_full, pclr, in_level} = '0;
		{uart_txd, rxd, dsr} = 3'b111;
		rst = 1'b1;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		void'($urandom(32'h97315ee6));
		// reset values and an unmapped offset
		apb(1'b0, OFS_CTRL, '0);
		check("ctrl reset", CTRL_RST, rd);
		apb(1'b0, OFS_BAUD, '0);
		check("baud reset", BAUD_RST, rd);
		apb(1'b0, 8'h14, '0);
		check("unmapped", 33'h1_0000_0000, {err, rd});
		// random pins, control byte and processor reset
		for (int i = 0; i < 40; i++) begin
			v = $urandom;
			p = &v[10:9];
			apb(1'b1, OFS_CTRL, {24'h0, v[23:16]});
			{rx_buffer_full, tx_buffer_empty, io_m, addr_a14, addr_a15, slot_select} <= v[5:0];
			{dsr, rxd, uart_txd} <= v[8:6];
			proc_reset_out <= p;
			ad_in <= v[31:24];
			ale <= 1'b1;
			@(posedge clk);
			ale <= 1'b0;
			repeat (5) @(posedge clk);
			check("decode", exp_dec(v[3:0], p), {data_buf_en_n, prog_rom_sel_n, scratch_ram_sel_n,
				serial_port_sel_n, id_buffer_sel_n});
			check("irq", exp_irq_n(v[17:16], v[5:4], p), card_irq_out_n);
			check("latch", v[31:24], latched_addr);
			check("serial", v[8:6], {dsr_seen, uart_rxd, txd});
			check("pod lines", v[23:20], {pod_choose_1, pod_choose_0, pod_ctrl_1, pod_ctrl_0});
			apb(1'b0, OFS_STATUS, '0);
			check("status", {1'b1, v[8], v[5:4]}, rd[3:0]);
		end
		proc_reset_out <= 1'b0;
		baud_run(16'h0002);
		baud_run(16'h0009);
		// card clock toggles every CARD_DIV/2 cycles
		n = 0;
		repeat (20) begin
			p = divided_card_clock;
			@(posedge clk);
			if (divided_card_clock !== p) n++;
		end
		check("card clock", 40 / CARD_DIV, n);
		// load a byte, shift it out msb first, fill from the pod
		for (int b = 0; b < 3; b++) begin
			v = (b == 0) ? 32'h0000_00A5 : $urandom;
			in_level <= b[0];
			apb(1'b1, OFS_CTRL, 32'h0000_0004);
			apb(1'b1, OFS_POD, {24'h0, v[7:0]});
			pod_cmd(2'b10, 1, 8'h1F);
			apb(1'b1, OFS_CTRL, 32'h0000_0000);
			pod_cmd(2'b01, 8, 8'h18);
			check("pod out", v[7:0], rx_byte);
			apb(1'b0, OFS_POD, '0);
			check("pod in", {8{b[0]}}, rd);
		end
		complete_run();
	end
endmodule : scoc_card_tb
`default_nettype wire

// ---- scoc_pkg.sv ----
/*
 * shared constants for the serial control option card: register map,
 * field positions, reset values and clock ratios.
 * assumes a 100 MHz system clock and 32-bit apb word addressing.
 */
package scoc_pkg;
	// apb register byte offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_POD    = 8'h04;
	localparam logic [7:0] OFS_COUNT  = 8'h08;
	localparam logic [7:0] OFS_BAUD   = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	// control register fields
	localparam int CTRL_IRQ_EN  = 0;
	localparam int CTRL_TX_GATE = 1;
	localparam int CTRL_LOAD    = 2;
	localparam int CTRL_POD_LO  = 4;
	// count register command bits
	localparam int CMD_CLEAR  = 0;
	localparam int CMD_PRESET = 1;
	// burst counter values
	localparam logic [3:0] CNT_PRESET = 4'hE;
	localparam logic [3:0] CNT_TC_8   = 4'h8;
	localparam logic [3:0] CNT_TC_1   = 4'hF;
	// reset values
	localparam logic [7:0]  CTRL_RST  = 8'h00;
	localparam logic [15:0] BAUD_RST  = 16'h0000;
	// processor clock 6.2016 MHz over card clock ~3.2 MHz
	localparam real PROC_CLK_MHZ = 6.2016;
	localparam real CARD_CLK_MHZ = 3.2;
	localparam int  CARD_DIV = int'(PROC_CLK_MHZ / CARD_CLK_MHZ);
	// last count of a half period, so the card clock period is CARD_DIV
	localparam logic [3:0] CARD_DIV_LAST = 4'(CARD_DIV / 2 - 1);
	// synchronised pin bundle width
	localparam int PIN_W = 20;
endpackage : scoc_pkg

// ---- scoc_pod_model.sv ----
/*
 * behavioural emulator pod: collects outbound bits on each shift clock
 * and holds the level the bench asks for on its inbound line.
 * assumes pod_shift_clock is a one-cycle high pulse in the clk domain.
 */
`timescale 1ns/1ps
`default_nettype none
module scoc_pod_model (
	// clock and bench control
	input  wire logic       clk,
	input  wire logic       clr,
	input  wire logic       in_level,
	// pod link
	input  wire logic       pod_shift_clock,
	input  wire logic       pod_outbound_line,
	output logic            pod_inbound_line,
	// what the pod has seen
	output logic [7:0]      rx_byte,
	output logic [3:0]      rx_count
);
	// steady inbound level, so a filled byte shows the level in every bit
	assign pod_inbound_line = in_level;
	// msb arrives first, so shift towards the top
	always_ff @(posedge clk) begin
		if (clr) begin
			rx_count <= 4'h0;
		end else if (pod_shift_clock) begin
			rx_byte  <= {rx_byte[6:0], pod_outbound_line};
			rx_count <= rx_count + 4'h1;
		end
	end
endmodule : scoc_pod_model
`default_nettype wire
